// file: hdl/serial_loader_pkg.sv
// Constants and types for the serial loader reply and record checker
`default_nettype none
package serial_loader_pkg;
  // ----------------------------------------------------------------
  // Reply codes and record fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_CMD = 8'h63;
  localparam logic [7:0] CODE_FRAME = 8'hA1;
  localparam logic [7:0] CODE_OVERRUN = 8'hA3;
  localparam logic [1:0] ERR_LAST = 2'h2;
  localparam logic [7:0] START_MARK = 8'h3A;
  localparam logic [7:0] TYPE_DATA = 8'h00;
  localparam logic [7:0] TYPE_END = 8'h01;
  localparam logic [7:0] TYPE_EXT = 8'h02;
  localparam logic [7:0] EXT_LEN = 8'h02;
  localparam logic [7:0] END_LEN = 8'h00;
  localparam logic [15:0] EXT_OFFSET = 16'h0000;
  localparam logic [15:0] SEG_LIMIT = 16'h2000;
  // ----------------------------------------------------------------
  // Checksum windows, 1-based byte positions
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_FIRST = 8'h09;
  localparam logic [7:0] ID_LAST = 8'h12;
  localparam logic [7:0] STAT_FIRST = 8'h09;
  localparam logic [7:0] STAT_LAST = 8'h0C;
  localparam int BUF_DEPTH = 2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SUM_MEM = 2'h0,
    SUM_ID = 2'h1,
    SUM_STATUS = 2'h2,
    SUM_RAM = 2'h3
  } sum_mode_t;
  typedef enum logic [6:0] {
    P_WAIT = 7'h01,
    P_LEN = 7'h02,
    P_OFFH = 7'h04,
    P_OFFL = 7'h08,
    P_TYPE = 7'h10,
    P_DATA = 7'h20,
    P_CSUM = 7'h40
  } parse_t;
  typedef enum logic [4:0] {
    T_RUN = 5'h01,
    T_ERR = 5'h02,
    T_SUMH = 5'h04,
    T_SUML = 5'h08,
    T_IDLE = 5'h10
  } talk_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0] data;
  } wr_t;
endpackage
`default_nettype wire

// file: hdl/serial_loader_record_checker.sv
// Serial loader: error replies, checksum replies and binary record parser
`default_nettype none
// Behaviour
// - On a command error, or a receive error while hex_enable is clear, send its code byte three times: 63h, A1h or A3h.
// - After any three-byte error code, stop talking and stay idle until reset.
// - A failed password check sends no error code bytes.
// - Checksum adds bytes singly; reply is 16-bit, upper byte then lower.
// - Erase, write, SUM, read, RAM load, ID and status commands return a checksum.
// - Product ID checksum covers transfer bytes nine to eighteen only.
// - Status output checksum covers transfer bytes nine to twelve only.
// - Erase checksum covers only erased bytes: whole array or erased sectors.
// - Write checksum covers the whole flash range, never record header fields.
// - SUM output checksum covers every byte of the flash array.
// - Read checksum covers only the flash bytes actually read out.
// - RAM load checksum covers the loaded RAM bytes, no header or checksum fields.
// - Records are raw binary and each starts with the 3Ah start mark.
// - After a record checksum, discard all bytes until the next start mark.
// - Receive error while hex_enable is set, or record format error, goes idle without any error code.
// - Only data, end and extended segment record types are accepted.
// - Record checksum is two's complement of header and data byte sum.
// - Extended record needs length two and offset zero.
// - Data record after a segment above 2000h is a format error.
// - End record with nonzero length is a format error.
module serial_loader_record_checker #(
  parameter int DEPTH = serial_loader_pkg::BUF_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire serial_loader_pkg::byte_t rx,
  input wire logic rx_framing_err,
  input wire logic rx_overrun_err,
  input wire logic cmd_error,
  input wire logic pwd_fail,
  input wire logic hex_enable,
  input wire serial_loader_pkg::sum_mode_t sum_mode,
  input wire logic sum_clear,
  input wire serial_loader_pkg::byte_t feed,
  input wire logic sum_send,
  output serial_loader_pkg::wr_t wr,
  output logic wr_valid,
  output logic end_seen,
  output logic idle,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import serial_loader_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  parse_t ps, next_ps;
  talk_t st, next_st;
  logic [7:0] len, next_len, typ, next_typ, rsum, next_rsum, cnt, next_cnt;
  logic [15:0] off, next_off, seg, next_seg, sum, next_sum;
  logic [7:0] code, next_code, pos, next_pos, push_data;
  logic [1:0] ecnt, next_ecnt;
  wr_t next_wr;
  logic next_wr_valid, next_end_seen, ferr, ram_add, pactive, push, in_ready;
  logic err_req, quiet, take;
  logic [7:0] mem [DEPTH];
  logic [7:0] next_mem [DEPTH];
  logic [PW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] count, next_count;
  // ----------------------------------------------------------------
  // Record parser
  // ----------------------------------------------------------------
  // Parser runs only while talking; idle freezes it until reset
  assign pactive = rx.valid && hex_enable && (st == T_RUN);
  always_comb begin
    next_ps = ps;
    next_len = len;
    next_off = off;
    next_typ = typ;
    next_rsum = rsum;
    next_cnt = cnt;
    next_seg = seg;
    next_wr = wr;
    next_wr_valid = 1'b0;
    next_end_seen = 1'b0;
    ferr = 1'b0;
    ram_add = 1'b0;
    if (pactive) begin
      case (ps)
        P_WAIT: begin
          if (rx.data == START_MARK) begin
            next_ps = P_LEN;
          end
        end
        P_LEN: begin
          next_len = rx.data;
          next_rsum = rx.data;
          next_ps = P_OFFH;
        end
        P_OFFH: begin
          next_off[15:8] = rx.data;
          next_rsum = 8'(rsum + rx.data);
          next_ps = P_OFFL;
        end
        P_OFFL: begin
          next_off[7:0] = rx.data;
          next_rsum = 8'(rsum + rx.data);
          next_ps = P_TYPE;
        end
        P_TYPE: begin
          next_typ = rx.data;
          next_rsum = 8'(rsum + rx.data);
          next_cnt = 8'h00;
          next_ps = (rx.data == TYPE_END) ? P_CSUM : P_DATA;
          ferr = (rx.data > TYPE_EXT)
              || (rx.data == TYPE_EXT && (len != EXT_LEN || off != EXT_OFFSET))
              || (rx.data == TYPE_END && len != END_LEN)
              || (rx.data == TYPE_DATA && (len == 8'h00 || seg > SEG_LIMIT));
        end
        P_DATA: begin
          next_rsum = 8'(rsum + rx.data);
          next_cnt = 8'(cnt + 8'h01);
          if (typ == TYPE_EXT) begin
            next_seg = {seg[7:0], rx.data};
          end else begin
            next_wr.addr = 20'({seg, 4'h0} + {4'h0, off} + {12'h000, cnt});
            next_wr.data = rx.data;
            next_wr_valid = 1'b1;
            ram_add = 1'b1;
          end
          if (next_cnt == len) begin
            next_ps = P_CSUM;
          end
        end
        P_CSUM: begin
          next_ps = P_WAIT;
          if (8'(rsum + rx.data) != 8'h00) begin
            ferr = 1'b1;
          end else if (typ == TYPE_END) begin
            next_end_seen = 1'b1;
          end
        end
        default: next_ps = P_WAIT;
      endcase
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ps <= P_WAIT;
      len <= 8'h00;
      off <= 16'h0000;
      typ <= 8'h00;
      rsum <= 8'h00;
      cnt <= 8'h00;
      seg <= 16'h0000;
      wr <= '0;
      wr_valid <= 1'b0;
      end_seen <= 1'b0;
    end else begin
      ps <= next_ps;
      len <= next_len;
      off <= next_off;
      typ <= next_typ;
      rsum <= next_rsum;
      cnt <= next_cnt;
      seg <= next_seg;
      wr <= next_wr;
      wr_valid <= next_wr_valid;
      end_seen <= next_end_seen;
    end
  end

  // ----------------------------------------------------------------
  // Reply control and checksum
  // ----------------------------------------------------------------
  // Receive errors inside a record phase stay silent; outside it they answer
  assign err_req = cmd_error || (!hex_enable && (rx_framing_err || rx_overrun_err));
  assign quiet = pwd_fail || ferr || (hex_enable && (rx_framing_err || rx_overrun_err));
  always_comb begin
    next_st = st;
    next_code = code;
    next_ecnt = ecnt;
    next_sum = sum;
    next_pos = pos;
    push = 1'b0;
    push_data = 8'h00;
    take = 1'b0;
    case (st)
      T_RUN: begin
        if (err_req) begin
          next_st = T_ERR;
          next_ecnt = 2'h0;
          next_code = (rx_framing_err && !hex_enable) ? CODE_FRAME :
                      ((rx_overrun_err && !hex_enable) ? CODE_OVERRUN : CODE_CMD);
        end else if (quiet) begin
          next_st = T_IDLE;
        end else if (sum_send) begin
          next_st = T_SUMH;
        end
      end
      T_ERR: begin
        push = 1'b1;
        push_data = code;
        if (in_ready) begin
          next_ecnt = 2'(ecnt + 2'h1);
          if (ecnt == ERR_LAST) begin
            next_st = T_IDLE;
          end
        end
      end
      T_SUMH: begin
        push = 1'b1;
        push_data = sum[15:8];
        if (in_ready) begin
          next_st = T_SUML;
        end
      end
      T_SUML: begin
        push = 1'b1;
        push_data = sum[7:0];
        if (in_ready) begin
          next_st = T_RUN;
        end
      end
      T_IDLE: next_st = T_IDLE;
      default: next_st = T_IDLE;
    endcase
    // Covered bytes are chosen upstream for erase, write, SUM and read
    if (sum_clear) begin
      next_sum = 16'h0000;
      next_pos = 8'h00;
    end else if (ram_add && sum_mode == SUM_RAM) begin
      next_sum = 16'(sum + {8'h00, rx.data});
    end else if (feed.valid) begin
      next_pos = (pos == 8'hFF) ? pos : 8'(pos + 8'h01);
      case (sum_mode)
        SUM_MEM: take = 1'b1;
        SUM_ID: take = next_pos >= ID_FIRST && next_pos <= ID_LAST;
        SUM_STATUS: take = next_pos >= STAT_FIRST && next_pos <= STAT_LAST;
        default: take = 1'b0;
      endcase
      if (take) begin
        next_sum = 16'(sum + {8'h00, feed.data});
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= T_RUN;
      code <= 8'h00;
      ecnt <= 2'h0;
      sum <= 16'h0000;
      pos <= 8'h00;
    end else begin
      st <= next_st;
      code <= next_code;
      ecnt <= next_ecnt;
      sum <= next_sum;
      pos <= next_pos;
    end
  end

  assign idle = (st == T_IDLE);
  // ----------------------------------------------------------------
  // Reply buffer
  // ----------------------------------------------------------------
  // A stalled receiver holds the reply sequencer instead of dropping bytes
  assign in_ready = (count != CW'(DEPTH));
  assign tx_valid = (count != '0);
  assign tx_data = mem[rptr];
  always_comb begin
    next_mem = mem;
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (push && in_ready) begin
      next_mem[wptr] = push_data;
      next_wptr = (wptr == PW'(DEPTH - 1)) ? '0 : PW'(wptr + 1'b1);
    end
    if (tx_valid && tx_ready) begin
      next_rptr = (rptr == PW'(DEPTH - 1)) ? '0 : PW'(rptr + 1'b1);
    end
    next_count = CW'(count + CW'(push && in_ready) - CW'(tx_valid && tx_ready));
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_err_last;
    st == T_ERR && in_ready && ecnt == ERR_LAST;
  endsequence
  sequence s_silent_idle;
    (st == T_IDLE && !push)[*3];
  endsequence
  AST_ERR_CODE: assert property ((st == T_ERR && in_ready) |->
      push && push_data == code && (code == CODE_CMD || code == CODE_FRAME
      || code == CODE_OVERRUN))
    else $error("error reply byte is not the latched code");
  AST_ERR_COUNT: assert property (($rose(st == T_ERR)) |-> ecnt == 2'h0)
    else $error("error reply did not start at its first copy");
  AST_ERR_IDLE: assert property (s_err_last |=> s_silent_idle)
    else $error("no silent idle after third error byte");
  AST_PWD_SILENT: assert property ((st == T_RUN && pwd_fail && !err_req) |=>
      s_silent_idle)
    else $error("password failure produced reply bytes");
  AST_SUM_ORDER: assert property ((st == T_SUMH && in_ready) |=>
      st == T_SUML && push_data == $past(sum[7:0]))
    else $error("checksum low byte does not follow high byte");
  AST_ID_WINDOW: assert property ((sum_mode == SUM_ID && feed.valid && !sum_clear
      && (pos >= ID_LAST || pos < 8'h08)) |=> $stable(sum))
    else $error("ID checksum took a byte outside its window");
  AST_STAT_WINDOW: assert property ((sum_mode == SUM_STATUS && feed.valid
      && !sum_clear && pos >= STAT_LAST) |=> $stable(sum))
    else $error("status checksum took a byte outside its window");
  AST_HUNT: assert property ((pactive && ps == P_WAIT && rx.data != START_MARK)
      |=> ps == P_WAIT && !wr_valid)
    else $error("byte between records was not discarded");
  AST_FMT_IDLE: assert property ((st == T_RUN && ferr && !err_req) |=>
      s_silent_idle)
    else $error("format error did not go silently idle");
  AST_BAD_CSUM: assert property ((pactive && ps == P_CSUM
      && 8'(rsum + rx.data) != 8'h00 && !err_req) |=> idle)
    else $error("record checksum mismatch was not caught");
endmodule
`default_nettype wire

// file: tb/reply_sink.sv
// Host-side receiver of the reply stream, with optional stalls
`default_nettype none
module reply_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  int cnt;
  initial begin
    tx_ready = 1'b0;
    cnt = 0;
  end
  // Ready one cycle in three when slow, so the two-entry buffer fills
  always @(negedge clock) begin
    cnt = cnt + 1;
    tx_ready = rst ? 1'b0 : (!slow || (cnt % 3 == 0));
  end
  always @(posedge clock) begin
    if (!rst && tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_data);
    end
  end
endmodule
`default_nettype wire

// file: tb/serial_loader_record_checker_tb_top.sv
// Self-checking bench for the serial loader record checker
`default_nettype none
module serial_loader_record_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_loader_pkg::*;
  // Starts low so that no false falling edge shortens the first reset
  logic clock = 1'b0;
  logic rst, rx_framing_err, rx_overrun_err, cmd_error, pwd_fail;
  logic hex_enable, sum_clear, sum_send, slow, wr_valid, end_seen, idle, tx_valid, tx_ready;
  logic [7:0] tx_data;
  byte_t rx, feed;
  sum_mode_t sum_mode;
  wr_t wr;
  int mismatches, tests_run, ends;
  wr_t wq [$];
  logic [7:0] bq [$];

  serial_loader_record_checker #(.DEPTH(BUF_DEPTH)) u_dut (.clock(clock), .rst(rst),
    .rx(rx), .rx_framing_err(rx_framing_err), .rx_overrun_err(rx_overrun_err),
    .cmd_error(cmd_error), .pwd_fail(pwd_fail), .hex_enable(hex_enable),
    .sum_mode(sum_mode), .sum_clear(sum_clear), .feed(feed), .sum_send(sum_send),
    .wr(wr), .wr_valid(wr_valid), .end_seen(end_seen), .idle(idle),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  reply_sink u_sink (.clock(clock), .rst(rst), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (wr_valid === 1'b1) wq.push_back(wr);
    if (end_seen === 1'b1) ends++;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [27:0] exp, logic [27:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    {rx, feed, rx_framing_err, rx_overrun_err, cmd_error, pwd_fail} = '0;
    {hex_enable, sum_clear, sum_send} = '0;
    sum_mode = SUM_MEM;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    wq.delete();
    u_sink.got.delete();
    ends = 0;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
    @(negedge clock);
  endtask
  task automatic wait_bytes(int n);
    int k;
    k = 0;
    while (u_sink.got.size() < n && k < 60) begin
      @(negedge clock);
      k++;
    end
    if (k >= 60) begin
      chk("reply count", n, u_sink.got.size());
      print_verdict();
    end
  endtask
  task automatic get_sum(logic [15:0] exp);
    u_sink.got.delete();
    pulse(sum_send);
    wait_bytes(2);
    repeat (4) @(negedge clock);
    chk("reply count", 2, u_sink.got.size());
    chk("sum high", exp[15:8], u_sink.got[0]);
    chk("sum low", exp[7:0], u_sink.got[1]);
  endtask
  // Record with data taken from the top of d; bad skews its checksum
  task automatic rec(logic [7:0] typ, logic [7:0] len, logic [15:0] off, logic [23:0] d,
                     int n, logic [7:0] bad);
    logic [7:0] s;
    s = len + off[15:8] + off[7:0] + typ;
    bq.push_back(START_MARK);
    bq.push_back(len);
    bq.push_back(off[15:8]);
    bq.push_back(off[7:0]);
    bq.push_back(typ);
    for (int i = 0; i < n; i++) begin
      bq.push_back(d[23-8*i -: 8]);
      s += d[23-8*i -: 8];
    end
    bq.push_back(8'h00 - s + bad);
  endtask
  task automatic send_bq();
    foreach (bq[i]) begin
      rx = {1'b1, bq[i]};
      @(negedge clock);
    end
    rx = '0;
    bq.delete();
    repeat (4) @(negedge clock);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_records();
    do_reset();
    hex_enable = 1'b1;
    sum_mode = SUM_RAM;
    pulse(sum_clear);
    rec(TYPE_DATA, 8'h01, 16'h0010, 24'h550000, 1, 8'h00);
    bq.push_back(8'h11);
    bq.push_back(8'h22);
    rec(TYPE_EXT, EXT_LEN, EXT_OFFSET, 24'h200000, 2, 8'h00);
    rec(TYPE_DATA, 8'h01, 16'h0020, 24'hAA0000, 1, 8'h00);
    rec(TYPE_END, END_LEN, 16'h0000, 24'h000000, 0, 8'h00);
    send_bq();
    chk("data bytes", 2, wq.size());
    chk("first byte", {20'h00010, 8'h55}, wq[0]);
    chk("segment byte", {20'h20020, 8'hAA}, wq[1]);
    chk("end seen", 1, ends);
    chk("idle", 1'b0, idle);
    hex_enable = 1'b0;
    get_sum(16'h00FF);
  endtask
  task automatic t_sums();
    sum_mode_t m [3] = '{SUM_MEM, SUM_ID, SUM_STATUS};
    logic [15:0] e [3] = '{16'h00D2, 16'h0087, 16'h002A};
    do_reset();
    slow = 1'b1;
    foreach (m[j]) begin
      sum_mode = m[j];
      pulse(sum_clear);
      for (int i = 1; i <= 20; i++) begin
        feed = {1'b1, 8'(i)};
        @(negedge clock);
      end
      feed = '0;
      get_sum(e[j]);
    end
    slow = 1'b0;
  endtask
  task automatic t_errors();
    logic [7:0] code [3] = '{CODE_FRAME, CODE_OVERRUN, CODE_CMD};
    for (int k = 0; k < 5; k++) begin
      do_reset();
      slow = 1'b1;
      hex_enable = (k == 4);
      case (k)
        0: pulse(rx_framing_err);
        1: pulse(rx_overrun_err);
        2: pulse(cmd_error);
        3: pulse(pwd_fail);
        default: pulse(rx_framing_err);
      endcase
      if (k < 3) wait_bytes(3);
      repeat (10) @(negedge clock);
      chk("error bytes", (k < 3) ? 3 : 0, u_sink.got.size());
      for (int i = 0; i < 3 && k < 3; i++) begin
        chk("error code", code[k], u_sink.got[i]);
      end
      chk("idle", 1'b1, idle);
      pulse(sum_send);
      repeat (10) @(negedge clock);
      chk("bytes after idle", (k < 3) ? 3 : 0, u_sink.got.size());
    end
    slow = 1'b0;
  endtask
  task automatic t_format();
    for (int f = 0; f < 6; f++) begin
      do_reset();
      hex_enable = 1'b1;
      case (f)
        0: rec(8'h03, 8'h01, 16'h0000, 24'h000000, 1, 8'h00);
        1: rec(TYPE_DATA, 8'h01, 16'h0010, 24'h550000, 1, 8'h01);
        2: rec(TYPE_EXT, 8'h03, EXT_OFFSET, 24'h001000, 3, 8'h00);
        3: rec(TYPE_EXT, EXT_LEN, 16'h0010, 24'h100000, 2, 8'h00);
        4: begin
          rec(TYPE_EXT, EXT_LEN, EXT_OFFSET, 24'h200100, 2, 8'h00);
          rec(TYPE_DATA, 8'h01, 16'h0000, 24'h550000, 1, 8'h00);
        end
        default: rec(TYPE_END, 8'h01, 16'h0000, 24'h000000, 1, 8'h00);
      endcase
      send_bq();
      chk("idle", 1'b1, idle);
      chk("end seen", 0, ends);
      chk("error bytes", 0, u_sink.got.size());
    end
  endtask
  initial begin
    mismatches = 0;
    tests_run = 0;
    slow = 1'b0;
    do_reset();
    t_records();
    t_sums();
    t_errors();
    t_format();
    print_verdict();
  end
endmodule
`default_nettype wire
